// [rtl/dgdpm_pin_if.sv]
// Synchronised pin samples passed from the pin synchroniser to the control core.
`timescale 1ns/1ns
`default_nettype none
interface dgdpm_pin_if import dgdpm_pkg::*;;
    logic ck_rise;
    logic cke_rise;
    logic cke;
    logic cs_n;
    logic reset_n;
    logic [CMD_W-1:0] cmd;
    logic [MR_W-1:0] mr_sel;
    logic [ADDR_W-1:0] addr;
    modport src (output ck_rise, cke_rise, cke, cs_n, reset_n, cmd, mr_sel, addr);
    modport dst (input ck_rise, cke_rise, cke, cs_n, reset_n, cmd, mr_sel, addr);
endinterface
`default_nettype wire

// [rtl/dgdpm_pin_sync.sv]
// Two-stage synchroniser for the memory pins with link clock and clock-enable edge detection.
`timescale 1ns/1ns
`default_nettype none
module dgdpm_pin_sync import dgdpm_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [PIN_W-1:0] pins_raw_i,
    dgdpm_pin_if.src pins
);
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic ck_d;
        logic cke_d;
    } dgdpm_sync_t;

    localparam dgdpm_sync_t SYNC_RESET = '{s1: PIN_RESET, s2: PIN_RESET,
        ck_d: 1'b0, cke_d: 1'b0};

    dgdpm_sync_t cur;
    dgdpm_sync_t next_s;

    // The first stage is read only by the second stage.
    always_comb begin
        next_s = cur;
        next_s.s1 = pins_raw_i;
        next_s.s2 = cur.s1;
        next_s.ck_d = cur.s2[P_CK];
        next_s.cke_d = cur.s2[P_CKE];
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= SYNC_RESET;
        end else begin
            cur <= next_s;
        end
    end

    assign pins.ck_rise = cur.s2[P_CK] & ~cur.ck_d;
    assign pins.cke_rise = cur.s2[P_CKE] & ~cur.cke_d;
    assign pins.cke = cur.s2[P_CKE];
    assign pins.cs_n = cur.s2[P_CS_N];
    assign pins.reset_n = cur.s2[P_RST_N];
    assign pins.cmd = cur.s2[P_CMD +: CMD_W];
    assign pins.mr_sel = cur.s2[P_MR +: MR_W];
    assign pins.addr = cur.s2[P_ADDR +: ADDR_W];
endmodule
`default_nettype wire

// [rtl/dgdpm_pkg.sv]
// Constants, types and timing for the gear-down and maximum power-saving control block.
package dgdpm_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int CNT_W = 16;
    localparam int CMD_W = 4;
    localparam int MR_W = 3;
    localparam int ADDR_W = 14;

    // Link-clock edge counts; the settle period must stay even.
    localparam logic [CNT_W-1:0] SYNC_SETTLE_NCK = 16'h0002;
    localparam logic [CNT_W-1:0] CMD_AFTER_SYNC_NCK = 16'h0004;
    localparam logic [CNT_W-1:0] DLL_LOCK_NCK = 16'h0300;
    localparam logic [CNT_W-1:0] DLL_EXIT_NCK = 16'h0280;
    localparam logic [CNT_W-1:0] POWER_SAVE_DLL_EXIT_NCK = 16'h0300;

    // Times in ns and their counts of system clock cycles, rounded up.
    localparam int SELF_REFRESH_EXIT_NS = 180;
    localparam int ABORT_EXIT_NS = 90;
    localparam int POWER_SAVE_ENTRY_DELAY_NS = 30;
    localparam int POWER_SAVE_EXIT_NS = 200;
    localparam logic [CNT_W-1:0] SELF_REFRESH_EXIT_CYC =
        16'((SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ABORT_EXIT_CYC =
        16'((ABORT_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] POWER_SAVE_ENTRY_CYC =
        16'((POWER_SAVE_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] POWER_SAVE_EXIT_CYC =
        16'((POWER_SAVE_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Commands as {act_n, ras_n, cas_n, we_n} with chip select low.
    localparam logic [CMD_W-1:0] CMD_MODE_SET = 4'h8;
    localparam logic [CMD_W-1:0] CMD_REFRESH = 4'h9;
    localparam logic [CMD_W-1:0] CMD_NO_OP = 4'hf;

    // Mode register select {bg0, ba1, ba0} and the bits this block decodes.
    localparam logic [MR_W-1:0] MR_SEL_THREE = 3'h3;
    localparam logic [MR_W-1:0] MR_SEL_FOUR = 3'h4;
    localparam int GEAR_BIT = 3;
    localparam int MPS_BIT = 1;

    // Layout of the sampled pin vector.
    localparam int PIN_W = 25;
    localparam int P_CK = 0;
    localparam int P_CKE = 1;
    localparam int P_CS_N = 2;
    localparam int P_RST_N = 3;
    localparam int P_CMD = 4;
    localparam int P_MR = 8;
    localparam int P_ADDR = 11;
    localparam logic [PIN_W-1:0] PIN_RESET = 25'h000_000c;

    typedef enum logic [3:0] {
        ST_RUN       = 4'h0,
        ST_SYNC_WAIT = 4'h1,
        ST_CMD_GEAR  = 4'h3,
        ST_SELF_REF  = 4'h4,
        ST_SR_EXIT   = 4'h5,
        ST_MPS_ENTRY = 4'h8,
        ST_MPS       = 4'hc,
        ST_MPS_EXIT  = 4'hd
    } dgdpm_state_t;

    typedef struct packed {
        dgdpm_state_t state;
        logic gear_2n;
        logic gear_window;
        logic init_phase;
        logic phase;
        logic dll_ready;
        logic [CNT_W-1:0] dll_tgt;
        logic [CNT_W-1:0] dll_cnt;
        logic [CNT_W-1:0] cnt;
        logic cmd_valid;
        logic [CMD_W-1:0] cmd_code;
        logic refused;
    } dgdpm_core_t;

    localparam dgdpm_core_t CORE_RESET = '{
        state: ST_RUN, gear_2n: 1'b0, gear_window: 1'b1, init_phase: 1'b1,
        phase: 1'b0, dll_ready: 1'b0, dll_tgt: DLL_LOCK_NCK, dll_cnt: 16'h0000,
        cnt: 16'h0000, cmd_valid: 1'b0, cmd_code: CMD_NO_OP, refused: 1'b0};

endpackage

// [rtl/dgdpm_top.sv]
// Gear-down (1N/2N) timing control and maximum power-saving mode control of the memory device.
//
// Summary of operation
// - Start in 1N; 2N needs mode-set plus sync.
// - Gear-down only at 2666 speed or faster.
// - Enter only at init or self refresh exit.
// - Even settle period; sync on even edge.
// - Init continues in 2N after command delay.
// - Self refresh entry reverts timing to 1N.
// - DLL commands wait for DLL exit delay.
// - Staying 1N needs only the exit delay.
// - Power-save answers only exit and reset.
// - After entry delay, ignore all but three pins.
// - Chip select high at enable rise: stay.
// - Chip select low at enable rise: exit.
`timescale 1ns/1ns
`default_nettype none
module dgdpm_top import dgdpm_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ck_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic reset_n_i,
    input wire logic act_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic bg0_i,
    input wire logic [1:0] ba_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic speed_2666_i,
    input wire logic sr_abort_i,
    output logic gear_2n_o,
    output logic self_refresh_o,
    output logic max_power_save_o,
    output logic cmd_ok_o,
    output logic dll_cmd_ok_o,
    output logic cmd_valid_o,
    output logic [CMD_W-1:0] cmd_code_o,
    output logic gear_refused_o
);
    dgdpm_pin_if pins ();

    dgdpm_pin_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i (rst_i),
        .pins_raw_i ({addr_i, bg0_i, ba_i, act_n_i, ras_n_i, cas_n_i, we_n_i,
                      reset_n_i, cs_n_i, cke_i, ck_i}),
        .pins (pins)
    );

    dgdpm_core_t cur;
    dgdpm_core_t next_s;

    logic take;
    logic gear_cmd;
    logic mps_cmd;
    logic dll_counting;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] dll_inc;
    logic [CNT_W-1:0] srx_cyc;

    assign cnt_inc = cur.cnt + 16'h0001;
    assign dll_inc = cur.dll_cnt + 16'h0001;
    assign srx_cyc = sr_abort_i ? ABORT_EXIT_CYC : SELF_REFRESH_EXIT_CYC;

    // In 2N only the even link edges counted from the sync pulse carry commands.
    assign take = (cur.state == ST_RUN) && pins.ck_rise && !pins.cs_n &&
                  (!cur.gear_2n || !cur.phase);
    assign gear_cmd = (pins.cmd == CMD_MODE_SET) && (pins.mr_sel == MR_SEL_THREE) &&
                      pins.addr[GEAR_BIT];
    assign mps_cmd = (pins.cmd == CMD_MODE_SET) && (pins.mr_sel == MR_SEL_FOUR) &&
                     pins.addr[MPS_BIT];
    // The DLL is off in self refresh and power save, so its wait only runs elsewhere.
    assign dll_counting = !cur.dll_ready && pins.ck_rise &&
                          (cur.state != ST_SELF_REF) && (cur.state != ST_SR_EXIT) &&
                          (cur.state != ST_MPS_ENTRY) && (cur.state != ST_MPS);

    always_comb begin
        next_s = cur;
        next_s.cmd_valid = 1'b0;
        next_s.refused = 1'b0;
        if (pins.ck_rise) begin
            next_s.phase = !cur.phase;
        end
        if (dll_counting) begin
            next_s.dll_cnt = dll_inc;
            if (dll_inc >= cur.dll_tgt) begin
                next_s.dll_ready = 1'b1;
            end
        end
        unique case (cur.state)
            ST_RUN: begin
                if (take) begin
                    next_s.cmd_valid = 1'b1;
                    next_s.cmd_code = pins.cmd;
                    if (gear_cmd) begin
                        // Entry only from 1N, at a fast speed grade, inside the window.
                        if (cur.gear_window && speed_2666_i && !cur.gear_2n) begin
                            next_s.state = ST_SYNC_WAIT;
                            next_s.cnt = 16'h0000;
                        end else begin
                            next_s.refused = 1'b1;
                        end
                    end else if (mps_cmd && !cur.gear_2n) begin
                        next_s.state = ST_MPS_ENTRY;
                        next_s.cnt = 16'h0000;
                        next_s.gear_window = 1'b0;
                    end else if (pins.cmd == CMD_REFRESH && !pins.cke) begin
                        next_s.state = ST_SELF_REF;
                        next_s.gear_2n = 1'b0;
                        next_s.gear_window = 1'b0;
                        next_s.init_phase = 1'b0;
                        next_s.dll_ready = 1'b0;
                    end else if (pins.cmd != CMD_REFRESH && pins.cmd != CMD_MODE_SET) begin
                        next_s.gear_window = 1'b0;
                    end
                end
            end
            ST_SYNC_WAIT: begin
                if (pins.ck_rise) begin
                    next_s.cnt = cnt_inc;
                    // The sync pulse counts only on an even edge after the settle period.
                    if (!pins.cs_n && cnt_inc >= SYNC_SETTLE_NCK && !cnt_inc[0]) begin
                        next_s.state = ST_CMD_GEAR;
                        next_s.cnt = 16'h0000;
                        next_s.phase = 1'b1;
                        next_s.dll_cnt = 16'h0000;
                        next_s.dll_ready = 1'b0;
                        next_s.dll_tgt = cur.init_phase ? DLL_LOCK_NCK : DLL_EXIT_NCK;
                        next_s.gear_window = 1'b0;
                    end
                end
            end
            ST_CMD_GEAR: begin
                if (pins.ck_rise) begin
                    next_s.cnt = cnt_inc;
                    if (cnt_inc >= CMD_AFTER_SYNC_NCK) begin
                        next_s.state = ST_RUN;
                        next_s.gear_2n = 1'b1;
                    end
                end
            end
            ST_SELF_REF: begin
                if (pins.cke_rise) begin
                    next_s.state = ST_SR_EXIT;
                    next_s.cnt = 16'h0000;
                    next_s.dll_cnt = 16'h0000;
                    next_s.dll_tgt = DLL_EXIT_NCK;
                end
            end
            ST_SR_EXIT: begin
                next_s.cnt = cnt_inc;
                if (cnt_inc >= srx_cyc) begin
                    next_s.state = ST_RUN;
                    next_s.gear_window = 1'b1;
                end
            end
            ST_MPS_ENTRY: begin
                next_s.cnt = cnt_inc;
                if (cnt_inc >= POWER_SAVE_ENTRY_CYC) begin
                    next_s.state = ST_MPS;
                    next_s.dll_ready = 1'b0;
                end
            end
            ST_MPS: begin
                // Clock receivers are off: chip select is judged at the enable rise alone.
                if (pins.cke_rise && !pins.cs_n) begin
                    next_s.state = ST_MPS_EXIT;
                    next_s.cnt = 16'h0000;
                    next_s.dll_cnt = 16'h0000;
                    next_s.dll_tgt = POWER_SAVE_DLL_EXIT_NCK;
                end
            end
            ST_MPS_EXIT: begin
                next_s.cnt = cnt_inc;
                if (cnt_inc >= POWER_SAVE_EXIT_CYC) begin
                    next_s.state = ST_RUN;
                end
            end
        endcase
        if (!pins.reset_n) begin
            next_s = CORE_RESET;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= CORE_RESET;
        end else begin
            cur <= next_s;
        end
    end

    assign gear_2n_o = cur.gear_2n;
    assign self_refresh_o = (cur.state == ST_SELF_REF) || (cur.state == ST_SR_EXIT);
    assign max_power_save_o = (cur.state == ST_MPS_ENTRY) || (cur.state == ST_MPS);
    assign cmd_ok_o = (cur.state == ST_RUN);
    assign dll_cmd_ok_o = (cur.state == ST_RUN) && cur.dll_ready;
    assign cmd_valid_o = cur.cmd_valid;
    assign cmd_code_o = cur.cmd_code;
    assign gear_refused_o = cur.refused;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    chk_reset_gear_1n: assert property (!pins.reset_n |=> !cur.gear_2n ##0 cur.gear_window)
        else $error("gear mode not 1N after reset pin");
    chk_gear_speed_gate: assert property ($rose(cur.state == ST_SYNC_WAIT) |-> $past(speed_2666_i))
        else $error("gear-down started below speed grade");
    chk_gear_window: assert property ($rose(cur.state == ST_SYNC_WAIT) |-> $past(cur.gear_window))
        else $error("gear-down started outside its window");
    chk_sync_even_edge: assert property ((cur.state == ST_SYNC_WAIT) && (next_s.state == ST_CMD_GEAR)
        |-> !cnt_inc[0] && cnt_inc >= SYNC_SETTLE_NCK)
        else $error("sync pulse taken on odd edge");
    chk_gear_after_cmd: assert property ($rose(cur.gear_2n) |-> $past(cur.state) == ST_CMD_GEAR
        && $past(cur.cnt) == CMD_AFTER_SYNC_NCK - 16'h0001)
        else $error("2N entered before command delay");
    chk_sr_reverts_1n: assert property ($rose(cur.state == ST_SELF_REF) |-> !cur.gear_2n
        ##1 !cur.gear_2n)
        else $error("self refresh kept 2N timing");
    chk_srx_delay: assert property ((cur.state == ST_SR_EXIT) && (next_s.state == ST_RUN)
        && pins.reset_n |-> cnt_inc == srx_cyc ##1 cur.gear_window)
        else $error("self refresh exit delay wrong");
    chk_mps_silent: assert property ((cur.state == ST_MPS) |=> !cur.cmd_valid && !cur.refused)
        else $error("command taken in power save");
    chk_mps_stay: assert property ((cur.state == ST_MPS) && pins.cke_rise && pins.cs_n
        && pins.reset_n |=> cur.state == ST_MPS)
        else $error("left power save with chip select high");
    chk_mps_exit: assert property ((cur.state == ST_MPS) && pins.cke_rise && !pins.cs_n
        && pins.reset_n |=> cur.state == ST_MPS_EXIT ##1 !max_power_save_o)
        else $error("power save exit not started");
    chk_mps_exit_time: assert property ($rose(cur.state == ST_MPS_EXIT) |-> !cmd_ok_o [*8])
        else $error("command allowed during exit time");

    // A reset pin pulse is legal at any time, so the timing checks exclude it.
    chk_gear_sync_1n: assert property ($rose(cur.state == ST_CMD_GEAR)
        |-> !cur.gear_2n)
        else $error("2N active before the command delay");
    chk_dll_restart: assert property ($rose(cur.state == ST_CMD_GEAR)
        |-> cur.dll_cnt == 16'h0000)
        else $error("DLL wait not restarted at sync");
    chk_dll_gate: assert property (dll_cmd_ok_o
        |-> cur.dll_cnt >= cur.dll_tgt)
        else $error("DLL commands allowed before the wait");
    chk_odd_edge_skip: assert property ((cur.state == ST_RUN) && cur.gear_2n
        && cur.phase && pins.ck_rise |=> !cur.cmd_valid)
        else $error("command taken on odd edge in 2N");
    chk_window_close: assert property (take && (pins.cmd != CMD_REFRESH)
        && (pins.cmd != CMD_MODE_SET) && pins.reset_n |=> !cur.gear_window)
        else $error("gear-down window left open");
    chk_refuse_2n: assert property (take && gear_cmd && cur.gear_2n && pins.reset_n
        |=> cur.refused && cur.gear_2n)
        else $error("gear mode-set in 2N not refused");
    chk_sr_entry: assert property (take && (pins.cmd == CMD_REFRESH) && !pins.cke
        && pins.reset_n |=> (cur.state == ST_SELF_REF) && !cur.gear_2n)
        else $error("self refresh not entered in 1N");
    chk_srx_back_1n: assert property ($fell(self_refresh_o)
        |-> !cur.gear_2n)
        else $error("self refresh exit left 2N timing");
    chk_mps_entry_time: assert property ($rose(cur.state == ST_MPS)
        |-> $past(cur.cnt) == POWER_SAVE_ENTRY_CYC - 16'h0001)
        else $error("power save entry delay wrong");
    chk_mps_reset_pin: assert property ((cur.state == ST_MPS) && !pins.reset_n
        |=> cur.state == ST_RUN)
        else $error("reset pin ignored in power save");
    chk_cmd_only_run: assert property (cur.cmd_valid
        |-> $past(cur.state) == ST_RUN)
        else $error("command taken outside run state");
    chk_mps_exit_count: assert property ($rose(cmd_ok_o)
        && $past(cur.state) == ST_MPS_EXIT && $past(pins.reset_n)
        |-> $past(cur.cnt) == POWER_SAVE_EXIT_CYC - 16'h0001)
        else $error("power save exit time wrong");

    cov_gear_entry: cover property ($rose(cur.gear_2n));
    cov_self_refresh: cover property ($fell(cur.state == ST_SR_EXIT) ##0 cur.state == ST_RUN);
    cov_mps_exit: cover property ($fell(cur.state == ST_MPS_EXIT));
    cov_gear_refused: cover property (cur.refused);
    cov_mps_stay: cover property ((cur.state == ST_MPS) && pins.cke_rise && pins.cs_n);
endmodule
`default_nettype wire

// [tb/dgdpm_ctrl_model.sv]
// Memory controller model that drives the link clock and command pins of the device.
`timescale 1ns/1ns
`default_nettype none
module dgdpm_ctrl_model import dgdpm_pkg::*; (
    input wire logic clk_sys_i,
    output logic ck_o,
    output logic cke_o,
    output logic cs_n_o,
    output logic reset_n_o,
    output logic [CMD_W-1:0] cmd_o,
    output logic [MR_W-1:0] mr_o,
    output logic [ADDR_W-1:0] addr_o
);
    int seed = 32'h0d32_1f63;

    initial begin
        ck_o = 1'b0;
        cke_o = 1'b0;
        cs_n_o = 1'b1;
        reset_n_o = 1'b1;
        cmd_o = CMD_NO_OP;
        mr_o = 3'h0;
        addr_o = 14'h0000;
    end

    // One link period of 17 system cycles; the clock stands still between calls.
    task automatic link_edge(input logic sel_n, input logic [CMD_W-1:0] c,
        input logic [MR_W-1:0] m, input logic [ADDR_W-1:0] a);
        @(negedge clk_sys_i);
        cs_n_o = sel_n;
        if (sel_n) begin
            // A deselected bus carries no value, so it is shown changing.
            cmd_o = CMD_W'($random(seed));
            mr_o = MR_W'($random(seed));
            addr_o = ADDR_W'($random(seed));
        end else begin
            cmd_o = c;
            mr_o = m;
            addr_o = a;
        end
        repeat (8) @(negedge clk_sys_i);
        ck_o = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        ck_o = 1'b0;
        cs_n_o = 1'b1;
        cmd_o = ~cmd_o;
        addr_o = ~addr_o;
    endtask

    // Clock enable and chip select move while the link clock is stopped.
    task automatic set_cke(input logic v, input logic sel_n);
        @(negedge clk_sys_i);
        cs_n_o = sel_n;
        cke_o = v;
        // A selected bus outside a link edge carries only the no-op command.
        if (!sel_n) begin
            cmd_o = CMD_NO_OP;
        end
    endtask

    task automatic pulse_reset();
        @(negedge clk_sys_i);
        reset_n_o = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        reset_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// [tb/test_dram_gear_down_and_deep_power_mode.sv]
// Self-checking bench for the gear-down and maximum power-saving control block.
`timescale 1ns/1ns
`default_nettype none
module test_dram_gear_down_and_deep_power_mode import dgdpm_pkg::*;;
    localparam logic [ADDR_W-1:0] GEAR_A = 14'h0008;
    localparam logic [ADDR_W-1:0] MPS_A = 14'h0002;
    // Even latency settings; the block passes these mode-sets through as plain commands.
    localparam logic [ADDR_W-1:0] GEAR_MR0_A = 14'h0024;
    localparam logic [ADDR_W-1:0] GEAR_MR1_A = 14'h0010;
    logic clk_sys_i;
    logic rst_i;
    logic speed_2666_i;
    logic sr_abort_i;
    logic ck, cke, cs_n, reset_n;
    logic [CMD_W-1:0] cmd;
    logic [MR_W-1:0] mr;
    logic [ADDR_W-1:0] addr;
    logic gear_2n_o, self_refresh_o, max_power_save_o, cmd_ok_o;
    logic dll_cmd_ok_o, cmd_valid_o, gear_refused_o;
    logic [CMD_W-1:0] cmd_code_o;
    logic [CMD_W-1:0] exp_code = CMD_NO_OP;
    logic [CMD_W-1:0] exp_q[$];
    int err_total = 0;
    int cmp_count = 0;
    int taken = 0;
    int refused = 0;
    int exp_refused = 0;
    int cyc = 0;
    int n, t0, lim;

    dgdpm_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ck_i(ck), .cke_i(cke),
        .cs_n_i(cs_n), .reset_n_i(reset_n), .act_n_i(cmd[3]), .ras_n_i(cmd[2]),
        .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bg0_i(mr[2]), .ba_i(mr[1:0]),
        .addr_i(addr), .speed_2666_i(speed_2666_i), .sr_abort_i(sr_abort_i),
        .gear_2n_o(gear_2n_o), .self_refresh_o(self_refresh_o),
        .max_power_save_o(max_power_save_o), .cmd_ok_o(cmd_ok_o),
        .dll_cmd_ok_o(dll_cmd_ok_o), .cmd_valid_o(cmd_valid_o),
        .cmd_code_o(cmd_code_o), .gear_refused_o(gear_refused_o));

    dgdpm_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .ck_o(ck), .cke_o(cke), .cs_n_o(cs_n),
        .reset_n_o(reset_n), .cmd_o(cmd), .mr_o(mr), .addr_o(addr));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Counts: %0d comparisons, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Pulses are sampled mid-cycle so the registered outputs have settled.
    always @(negedge clk_sys_i) begin
        cyc++;
        if (cmd_valid_o === 1'b1) begin
            taken++;
            check(16'(exp_q.size() > 0), 16'h0001);
            if (exp_q.size() > 0) begin
                exp_code = exp_q.pop_front();
            end
            check(16'(cmd_code_o), 16'(exp_code));
        end
        if (gear_refused_o === 1'b1) begin
            refused++;
        end
        if (cyc == 30000) begin
            err_total++;
            summarize();
        end
    end

    task automatic do_reset(input logic spd, input logic ab);
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        speed_2666_i = spd;
        sr_abort_i = ab;
        repeat (12) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        u_ctrl.set_cke(1'b1, 1'b1);
    endtask

    task automatic send(input logic [CMD_W-1:0] c, input logic [MR_W-1:0] m,
        input logic [ADDR_W-1:0] a);
        exp_q.push_back(c);
        u_ctrl.link_edge(1'b0, c, m, a);
    endtask

    task automatic idle(input int k);
        repeat (k) u_ctrl.link_edge(1'b1, CMD_NO_OP, 3'h0, 14'h0000);
    endtask

    task automatic wait_ok(output int cnt);
        cnt = 0;
        while (cmd_ok_o !== 1'b1 && cnt < 200) begin
            @(negedge clk_sys_i);
            cnt++;
        end
    endtask

    task automatic gear_up();
        t0 = taken;
        send(CMD_MODE_SET, MR_SEL_THREE, GEAR_A);
        check(16'(taken - t0), 16'h0001);
        check(16'(cmd_ok_o), 16'h0000);
        u_ctrl.link_edge(1'b0, CMD_NO_OP, 3'h0, 14'h0000);
        u_ctrl.link_edge(1'b0, CMD_NO_OP, 3'h0, 14'h0000);
        idle(3);
        check(16'(gear_2n_o), 16'h0000);
        idle(1);
        check(16'(gear_2n_o), 16'h0001);
        check(16'(cmd_ok_o), 16'h0001);
    endtask

    initial begin
        rst_i = 1'b1;
        speed_2666_i = 1'b0;
        sr_abort_i = 1'b0;
        do_reset(1'b0, 1'b0);
        check(16'({gear_2n_o, self_refresh_o, max_power_save_o}), 16'h0000);
        check(16'({cmd_ok_o, dll_cmd_ok_o, cmd_code_o}), 16'h002f);
        send(CMD_MODE_SET, MR_SEL_THREE, GEAR_A);
        exp_refused++;
        check(16'(refused), 16'(exp_refused));
        idle(6);
        check(16'(gear_2n_o), 16'h0000);
        $display("Test slow grade done");
        do_reset(1'b1, 1'b0);
        send(4'hd, 3'h0, 14'h0400);
        send(CMD_MODE_SET, MR_SEL_THREE, GEAR_A);
        exp_refused++;
        check(16'(refused), 16'(exp_refused));
        $display("Test closed window done");
        do_reset(1'b1, 1'b0);
        gear_up();
        idle(1);
        send(CMD_MODE_SET, MR_SEL_THREE, GEAR_A);
        exp_refused++;
        check(16'(refused), 16'(exp_refused));
        t0 = taken;
        idle(1);
        send(CMD_MODE_SET, 3'h0, GEAR_MR0_A);
        idle(1);
        send(CMD_MODE_SET, 3'h1, GEAR_MR1_A);
        check(16'(taken - t0), 16'h0002);
        for (int ab = 0; ab < 2; ab++) begin
            sr_abort_i = ab[0];
            idle(1);
            u_ctrl.set_cke(1'b0, 1'b1);
            send(CMD_REFRESH, 3'h0, 14'h0000);
            check(16'({self_refresh_o, gear_2n_o}), 16'h0002);
            u_ctrl.set_cke(1'b1, 1'b1);
            wait_ok(n);
            lim = (ab == 1) ? int'(ABORT_EXIT_CYC) : int'(SELF_REFRESH_EXIT_CYC);
            check(16'(n >= lim && n <= lim + 6), 16'h0001);
            check(16'({self_refresh_o, gear_2n_o}), 16'h0000);
        end
        send(CMD_REFRESH, 3'h0, 14'h0000);
        gear_up();
        idle(600);
        check(16'(dll_cmd_ok_o), 16'h0000);
        idle(60);
        check(16'(dll_cmd_ok_o), 16'h0001);
        $display("Test gear-down and self refresh done");
        do_reset(1'b1, 1'b0);
        send(CMD_MODE_SET, MR_SEL_FOUR, MPS_A);
        check(16'({max_power_save_o, cmd_ok_o}), 16'h0002);
        t0 = taken;
        send(CMD_MODE_SET, MR_SEL_THREE, GEAR_A);
        check(16'(taken - t0), 16'h0000);
        check(16'(exp_q.size()), 16'h0001);
        exp_q.delete();
        u_ctrl.set_cke(1'b0, 1'b1);
        u_ctrl.set_cke(1'b1, 1'b1);
        repeat (30) @(negedge clk_sys_i);
        check(16'({max_power_save_o, cmd_ok_o}), 16'h0002);
        u_ctrl.set_cke(1'b0, 1'b1);
        u_ctrl.set_cke(1'b1, 1'b0);
        u_ctrl.set_cke(1'b1, 1'b1);
        wait_ok(n);
        lim = int'(POWER_SAVE_EXIT_CYC);
        check(16'(n >= lim && n <= lim + 6), 16'h0001);
        check(16'(max_power_save_o), 16'h0000);
        send(CMD_MODE_SET, MR_SEL_FOUR, MPS_A);
        check(16'(max_power_save_o), 16'h0001);
        u_ctrl.pulse_reset();
        repeat (6) @(negedge clk_sys_i);
        check(16'({max_power_save_o, cmd_ok_o}), 16'h0001);
        $display("Test power saving done");
        check(16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
